/* File: bench/uab_autobaud_tb.sv */
/*
  self-checking bench for the auto-baud block: register port tasks, random
  sync frames at every prescale, break path, sync refusal and bit rate.
  assumes the register port answers reads one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module uab_autobaud_tb;
  // cycle ceiling, the whole run needs well under half of it
  localparam int CYC_MAX = 100000;
  // clock, reset and register port
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata;
  // serial line and status outputs
  logic pin;
  logic receive_flag, ovf_flag, ab_mode, rx_idle, bit_tick;
  // partner request
  logic go = 1'b0;
  logic brk = 1'b0;
  logic [15:0] bit_clks = 16'h0001;
  logic snd_busy;
  // bookkeeping
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;

  // 100 mhz clock
  always #5 clk = ~clk;

  uab_autobaud u_uab_autobaud (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .serial_input_pin(pin),
    .receive_flag(receive_flag), .autobaud_overflow_flag(ovf_flag),
    .autobaud_mode(ab_mode), .rx_hold_idle(rx_idle), .bit_tick(bit_tick));
  uab_sync_sender u_uab_sync_sender (.clk(clk), .go(go), .with_break(brk),
    .bit_clks(bit_clks), .line(pin), .busy(snd_busy));

  // single place where the run ends
  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one compare for every value the bench checks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // single-cycle write; the idle edge after it keeps strobes apart
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  // read and compare; data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp}, what);
    @(posedge clk);
  endtask

  // counter clock period in system clocks for the two speed selects
  function automatic int pre_clks(input logic wide, input logic high);
    return (wide && high) ? 32 : ((wide || high) ? 128 : 512);
  endfunction

  // send one frame and wait, bounded, for the line to go idle again
  task automatic frame(input int b, input logic with_brk);
    bit_clks <= b[15:0];
    brk <= with_brk;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 40000 && snd_busy === 1'b1; k++) begin
      @(posedge clk);
    end
  endtask

  // full measurement; bit time sits half a tick off any boundary
  task automatic measure(input logic wide, input logic high, input logic wake, input int n);
    int p;
    logic [7:0] ctl;
    p = pre_clks(wide, high);
    ctl = (8'(wake) << uab_pkg::BIT_WAKE_EN) | (8'(wide) << uab_pkg::BIT_WIDE);
    wr(uab_pkg::ADDR_DIV_LOW, 8'h80 | 8'($urandom));
    wr(uab_pkg::ADDR_TX_CTRL, 8'(high) << uab_pkg::BIT_HIGH_SPEED);
    // armed only with nothing in flight, and no transmit write while armed
    wr(uab_pkg::ADDR_RATE_CTRL, ctl | 8'h01);
    rd_chk(uab_pkg::ADDR_STATUS, 8'h02, "busy after arm");
    chk({15'h0, rx_idle}, 16'h1, "receiver held idle");
    rd_chk(uab_pkg::ADDR_DIV_LOW, 8'h00, "divisor cleared on arm");
    frame(p / 8 * n + p / 16, wake);
    rd_chk(uab_pkg::ADDR_DIV_LOW, n[7:0], "measured count");
    rd_chk(uab_pkg::ADDR_DIV_HIGH, 8'h00, "count high byte");
    chk({15'h0, receive_flag}, 16'h1, "receive flag set");
    chk({15'h0, ab_mode}, 16'h0, "measurement ended");
    rd_chk(uab_pkg::ADDR_RATE_CTRL, ctl, "enable auto-cleared");
    rd_chk(uab_pkg::ADDR_RX_BUF, 8'h00, "buffer read");
    chk({15'h0, receive_flag}, 16'h0, "receive flag cleared");
  endtask

  // spacing of bit rate pulses in high speed wide mode
  task automatic tick_gap(input logic [7:0] d);
    int n;
    wr(uab_pkg::ADDR_TX_CTRL, 8'(1) << uab_pkg::BIT_HIGH_SPEED);
    wr(uab_pkg::ADDR_RATE_CTRL, 8'(1) << uab_pkg::BIT_WIDE);
    wr(uab_pkg::ADDR_DIV_HIGH, 8'h00);
    wr(uab_pkg::ADDR_DIV_LOW, d);
    // first pass finds a pulse, second measures the gap to the next
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (bit_tick !== 1'b1 && n < 2000);
    end
    chk(n[15:0], 16'(4 * (d + 1)), "bit tick spacing");
    @(posedge clk);
  endtask

  // hang guard: running out counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX) begin
      error_cnt++;
      conclude();
    end
  end

  // main sequence
  initial begin
    logic [7:0] v;
    logic [7:0] w;
    void'($urandom(32'h8699));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // every index reads zero after reset, unmapped ones included
    for (int a = 0; a < 8; a++) begin
      rd_chk(3'(a), 8'h00, "reset value");
    end
    wr(3'h6, 8'hff);
    rd_chk(3'h6, 8'h00, "unmapped index");
    // divisor pair written and read as two independent bytes
    v = 8'($urandom);
    w = 8'($urandom);
    wr(uab_pkg::ADDR_DIV_LOW, v);
    wr(uab_pkg::ADDR_DIV_HIGH, w);
    rd_chk(uab_pkg::ADDR_DIV_LOW, v, "divisor low");
    rd_chk(uab_pkg::ADDR_DIV_HIGH, w, "divisor high");
    // software may set and clear the overflow flag
    wr(uab_pkg::ADDR_RATE_CTRL, 8'(1) << uab_pkg::BIT_AB_OVF);
    rd_chk(uab_pkg::ADDR_RATE_CTRL, 8'h80, "overflow set by write");
    chk({15'h0, ovf_flag}, 16'h1, "overflow output");
    wr(uab_pkg::ADDR_RATE_CTRL, 8'h00);
    chk({15'h0, ovf_flag}, 16'h0, "overflow cleared by write");
    // every speed select pair with a random count
    for (int s = 0; s < 4; s++) begin
      measure(s[1], s[0], 1'b0, 2 + $urandom % 8);
    end
    // wake-up set: only the frame after the break is measured
    measure(1'b1, 1'b1, 1'b1, 2 + $urandom % 8);
    // synchronous mode refuses to measure
    wr(uab_pkg::ADDR_TX_CTRL, 8'(1) << uab_pkg::BIT_SYNC);
    wr(uab_pkg::ADDR_RATE_CTRL, 8'h01);
    frame(40, 1'b0);
    chk({15'h0, receive_flag}, 16'h0, "no measure in sync mode");
    wr(uab_pkg::ADDR_RATE_CTRL, 8'h00);
    wr(uab_pkg::ADDR_TX_CTRL, 8'h00);
    tick_gap(8'(1 + $urandom % 7));
    conclude();
  end
endmodule
`default_nettype wire

/* File: bench/uab_sync_sender.sv */
/*
  model of the remote transmitter that sends the 55h calibration frame,
  optionally after a long break.
  assumes the bench pulses go for one cycle while busy is low.
*/
`timescale 1ns/1ps
`default_nettype none
module uab_sync_sender (
  // clock
  input wire logic clk,
  // request from the bench
  input wire logic go,
  input wire logic with_break,
  input wire logic [15:0] bit_clks,
  // serial line and state
  output logic line,
  output logic busy
);
  // alternating bits give exactly five rising edges per frame
  localparam logic [7:0] SYNC_BYTE = 8'h55;

  // hold the line at one level for n clocks
  task automatic hold(input logic lvl, input int n);
    line <= lvl;
    repeat (n) @(posedge clk);
  endtask

  // line idles high, as a pulled-up receive line would; one process owns
  // both outputs so each has a single driver
  // one frame per request: optional break, then start, data, stop
  initial begin
    line = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go && !busy) begin
        busy <= 1'b1;
        // break is longer than any frame so it can never pass for one
        if (with_break) begin
          hold(1'b0, 13 * bit_clks);
          hold(1'b1, bit_clks);
        end
        hold(1'b0, bit_clks);
        for (int i = 0; i < 8; i++) begin
          hold(SYNC_BYTE[i], bit_clks);
        end
        hold(1'b1, bit_clks);
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hdl/uab_autobaud.sv */
/*
  auto-baud measurement for an asynchronous serial port, with its register
  port, the 16-bit divisor pair used as counter and the high speed bit rate.
  assumes serial_input_pin is already synchronous to clk and idles high.
*/
// Implementation choices: the strobed register port and the address map.
// How it works
// - measure only in async mode
// - start bit with enable begins measurement
// - enable clears divisor, then waits start
// - count prescaled ticks from first rising edge
// - fifth rising edge stops, divisor holds count
// - fifth rising edge clears the enable
// - counter wrap sets overflow flag
// - overflow flag: hardware sets, software writes
// - wrap keeps measurement and enable running
// - counter runs at one eighth rate
// - prescale 512, 128 or 32 clocks
// - divisor pair counts as one 16-bit
// - receiver held idle during measurement
// - fifth rising edge raises receive flag
// - buffer read clears flag, value discarded
// - wake-up set: measure after break
// - frame: start, 8 or 9 data, stop
// - data bits sent lsb first
`timescale 1ns/1ps
`default_nettype none
module uab_autobaud (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // serial line
  input wire logic serial_input_pin,
  // status to the rest of the port
  output logic receive_flag,
  output logic autobaud_overflow_flag,
  output logic autobaud_mode,
  output logic rx_hold_idle,
  output logic bit_tick
);
  // software state
  logic autobaud_enable_r; // starts and tracks a measurement
  logic wake_up_enable_r; // measure after a break
  logic wide_divisor_select_r; // 16-bit divisor select
  logic high_speed_select_r; // high speed select
  logic sync_mode_r; // synchronous mode blocks measurement
  logic ovf_r; // autobaud_overflow_flag
  logic rx_flag_r; // receive_flag
  logic [7:0] div_low_r; // rate_divisor_low
  logic [7:0] div_high_r; // rate_divisor_high
  logic [7:0] rdata_r; // read data, valid one cycle after strobe
  // sequencer state
  uab_pkg::uab_state_type st_r;
  uab_pkg::uab_state_type st_nxt;
  logic [2:0] edge_r; // rising edges seen so far
  logic [2:0] edge_nxt;
  logic rx_prev_r; // last line level for edge detection
  logic busy_r; // measurement in progress, visible copy
  // bit rate generator state
  logic [15:0] rate_cnt_r;
  logic [1:0] quarter_r;
  logic tick_out_r;

  // decode of the register port
  wire wr_ctrl = wr_en && (addr == uab_pkg::ADDR_RATE_CTRL);
  wire wr_low = wr_en && (addr == uab_pkg::ADDR_DIV_LOW);
  wire wr_high = wr_en && (addr == uab_pkg::ADDR_DIV_HIGH);
  wire wr_tx = wr_en && (addr == uab_pkg::ADDR_TX_CTRL);
  wire rd_buf = rd_en && (addr == uab_pkg::ADDR_RX_BUF);

  // line edges; the pin is taken as synchronous already
  wire rx_rise = serial_input_pin && !rx_prev_r;
  wire rx_fall = !serial_input_pin && rx_prev_r;

  // the divisor pair is one counter whatever the width select says
  wire [15:0] div_full = {div_high_r, div_low_r};
  wire [16:0] div_inc = {1'b0, div_full} + 17'h00001;

  // prescale tick; its rate is one eighth of the normal rate clock
  wire pre_tick;
  wire pre_clear = (st_r == uab_pkg::ST_WAIT_RISE) && rx_rise;
  wire pre_run = (st_r == uab_pkg::ST_COUNT);
  wire [1:0] sel_count = {1'b0, wide_divisor_select_r} + {1'b0, high_speed_select_r};

  uab_prescaler u_pre (
    .clk(clk),
    .rst(rst),
    .clear(pre_clear),
    .run(pre_run),
    .sel_count(sel_count),
    .tick(pre_tick)
  );

  // events of the measurement
  wire counting = (st_r == uab_pkg::ST_COUNT);
  wire count_step = counting && pre_tick;
  // a tick that meets the fifth edge is not counted, so it cannot wrap either
  wire wrap = count_step && !fifth_edge && div_inc[16];
  // the 55h pattern sent lsb first gives five rising edges, stop bit last
  wire fifth_edge = counting && rx_rise && (edge_r == (uab_pkg::EDGE_LAST - 3'h1));
  wire enable_set = wr_ctrl && wdata[uab_pkg::BIT_AB_EN];
  wire enable_drop = wr_ctrl && !wdata[uab_pkg::BIT_AB_EN];

  // sequencer next state
  always_comb begin
    st_nxt = st_r;
    edge_nxt = edge_r;
    if (sync_mode_r || enable_drop) begin
      st_nxt = uab_pkg::ST_IDLE;
    end else if (enable_set) begin
      st_nxt = uab_pkg::ST_CLEAR;
    end else begin
      unique case (st_r)
        uab_pkg::ST_IDLE: begin
          st_nxt = uab_pkg::ST_IDLE;
        end
        uab_pkg::ST_CLEAR: begin
          // divisor is zeroed in this cycle; next look for start or break
          st_nxt = wake_up_enable_r ? uab_pkg::ST_BREAK_LOW : uab_pkg::ST_WAIT_START;
        end
        uab_pkg::ST_BREAK_LOW: begin
          if (!serial_input_pin) begin
            st_nxt = uab_pkg::ST_BREAK_END;
          end
        end
        uab_pkg::ST_BREAK_END: begin
          // the character after the break is the one measured
          if (rx_rise) begin
            st_nxt = uab_pkg::ST_WAIT_START;
          end
        end
        uab_pkg::ST_WAIT_START: begin
          if (rx_fall) begin
            st_nxt = uab_pkg::ST_WAIT_RISE;
          end
        end
        uab_pkg::ST_WAIT_RISE: begin
          if (rx_rise) begin
            st_nxt = uab_pkg::ST_COUNT;
            edge_nxt = 3'h1;
          end
        end
        uab_pkg::ST_COUNT: begin
          if (fifth_edge) begin
            st_nxt = uab_pkg::ST_IDLE;
            edge_nxt = 3'h0;
          end else if (rx_rise) begin
            edge_nxt = edge_r + 3'h1;
          end
        end
        default: begin
          // unused code: fall back to idle
          st_nxt = uab_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= uab_pkg::ST_IDLE;
      edge_r <= 3'h0;
      rx_prev_r <= 1'b1;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      edge_r <= edge_nxt;
      rx_prev_r <= serial_input_pin;
      busy_r <= (st_nxt != uab_pkg::ST_IDLE);
    end
  end

  // software controls; a software set of the enable beats the hardware clear
  always_ff @(posedge clk) begin
    if (rst) begin
      autobaud_enable_r <= 1'b0;
      wake_up_enable_r <= 1'b0;
      wide_divisor_select_r <= 1'b0;
      high_speed_select_r <= 1'b0;
      sync_mode_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        autobaud_enable_r <= wdata[uab_pkg::BIT_AB_EN];
        wake_up_enable_r <= wdata[uab_pkg::BIT_WAKE_EN];
        wide_divisor_select_r <= wdata[uab_pkg::BIT_WIDE];
      end else if (fifth_edge || sync_mode_r) begin
        autobaud_enable_r <= 1'b0;
      end
      if (wr_tx) begin
        high_speed_select_r <= wdata[uab_pkg::BIT_HIGH_SPEED];
        sync_mode_r <= wdata[uab_pkg::BIT_SYNC];
      end
    end
  end

  // overflow flag: a wrap in the same cycle beats a software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_r <= 1'b0;
    end else if (wrap) begin
      ovf_r <= 1'b1;
    end else if (wr_ctrl) begin
      ovf_r <= wdata[uab_pkg::BIT_AB_OVF];
    end
  end

  // receive flag: set by the fifth edge, cleared by a buffer read
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_flag_r <= 1'b0;
    end else if (fifth_edge) begin
      rx_flag_r <= 1'b1;
    end else if (rd_buf) begin
      rx_flag_r <= 1'b0;
    end
  end

  // divisor pair: zeroed on arm, counted during measurement, else software
  // writes during a measurement are dropped so the count stays honest
  always_ff @(posedge clk) begin
    if (rst) begin
      div_low_r <= uab_pkg::RST_BYTE;
      div_high_r <= uab_pkg::RST_BYTE;
    end else if (st_r == uab_pkg::ST_CLEAR) begin
      div_low_r <= uab_pkg::RST_BYTE;
      div_high_r <= uab_pkg::RST_BYTE;
    end else if (count_step && !fifth_edge) begin
      div_low_r <= div_inc[7:0];
      div_high_r <= div_inc[15:8];
    end else if (!busy_r) begin
      if (wr_low) begin
        div_low_r <= wdata;
      end
      if (wr_high) begin
        div_high_r <= wdata;
      end
    end
  end

  // read mux; receive buffer reads zero as its value is discarded
  wire [7:0] ctrl_rd = {ovf_r, 3'h0, wide_divisor_select_r, 1'b0,
                        wake_up_enable_r, autobaud_enable_r};
  wire [7:0] tx_rd = {3'h0, sync_mode_r, 1'b0, high_speed_select_r, 2'h0};
  wire [7:0] stat_rd = {6'h00, busy_r, rx_flag_r};
  wire [7:0] rd_mux = (addr == uab_pkg::ADDR_RATE_CTRL) ? ctrl_rd :
                      (addr == uab_pkg::ADDR_DIV_LOW) ? div_low_r :
                      (addr == uab_pkg::ADDR_DIV_HIGH) ? div_high_r :
                      (addr == uab_pkg::ADDR_STATUS) ? stat_rd :
                      (addr == uab_pkg::ADDR_TX_CTRL) ? tx_rd : 8'h00;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_en ? rd_mux : 8'h00;
    end
  end

  // high speed 16-bit bit rate: reload every divisor+1 clocks, tick each 4th
  wire rate_on = !busy_r && !sync_mode_r && wide_divisor_select_r && high_speed_select_r;
  wire rate_zero = (rate_cnt_r == 16'h0000);
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_cnt_r <= uab_pkg::RST_DIV;
      quarter_r <= 2'h0;
      tick_out_r <= 1'b0;
    end else if (!rate_on) begin
      rate_cnt_r <= div_full;
      quarter_r <= 2'h0;
      tick_out_r <= 1'b0;
    end else begin
      rate_cnt_r <= rate_zero ? div_full : rate_cnt_r - 16'h0001;
      quarter_r <= rate_zero ? quarter_r + 2'h1 : quarter_r;
      tick_out_r <= rate_zero && (quarter_r == uab_pkg::QUARTER_LAST);
    end
  end

  // outputs, all from flops
  assign rdata = rdata_r;
  assign receive_flag = rx_flag_r;
  assign autobaud_overflow_flag = ovf_r;
  assign autobaud_mode = busy_r;
  assign rx_hold_idle = busy_r;
  assign bit_tick = tick_out_r;

  // checks
  wire quiet = !wr_ctrl && !sync_mode_r;

  a_sync_blocks_run: assert property (@(posedge clk) disable iff (rst)
    sync_mode_r |=> st_r == uab_pkg::ST_IDLE)
    else $error("measurement running in sync mode");

  a_start_bit_begin: assert property (@(posedge clk) disable iff (rst)
    (st_r == uab_pkg::ST_WAIT_START) && rx_fall && quiet |=> st_r == uab_pkg::ST_WAIT_RISE)
    else $error("start bit did not begin measurement");

  a_arm_clears_div: assert property (@(posedge clk) disable iff (rst)
    enable_set && !sync_mode_r |=> ##1 (div_full == 16'h0000) && !counting)
    else $error("divisor not cleared on arm");

  a_count_step_inc: assert property (@(posedge clk) disable iff (rst)
    count_step && !fifth_edge && quiet |=> div_full == $past(div_full) + 16'h0001)
    else $error("divisor did not count on tick");

  a_fifth_edge_done: assert property (@(posedge clk) disable iff (rst)
    fifth_edge && quiet |=> !autobaud_enable_r && rx_flag_r && (st_r == uab_pkg::ST_IDLE)
      ##1 !busy_r)
    else $error("fifth edge did not close measurement");

  a_wrap_sets_ovf: assert property (@(posedge clk) disable iff (rst)
    wrap |=> ovf_r && (div_full == 16'h0000))
    else $error("wrap did not set overflow");

  a_wrap_keeps_run: assert property (@(posedge clk) disable iff (rst)
    wrap && !fifth_edge && quiet |=> autobaud_enable_r && counting)
    else $error("wrap stopped measurement");

  a_hold_rx_idle: assert property (@(posedge clk) disable iff (rst)
    (st_r != uab_pkg::ST_IDLE) && $past(st_r != uab_pkg::ST_IDLE) |-> rx_hold_idle)
    else $error("receiver not held idle");

  a_read_clears_flag: assert property (@(posedge clk) disable iff (rst)
    rd_buf && !fifth_edge |=> !rx_flag_r)
    else $error("buffer read left receive flag set");

  c_full_measure: cover property (@(posedge clk) disable iff (rst) fifth_edge);
  c_overflow: cover property (@(posedge clk) disable iff (rst) wrap);
  c_after_break: cover property (@(posedge clk) disable iff (rst)
    (st_r == uab_pkg::ST_BREAK_END) && rx_rise);
  c_bit_rate: cover property (@(posedge clk) disable iff (rst) tick_out_r);
endmodule
`default_nettype wire

/* File: hdl/uab_pkg.sv */
/*
  constants shared by the auto-baud measurement block: register offsets,
  bit positions, reset values, state codes and prescale counts.
  assumes an 8-bit register port with a 3-bit word address.
*/
package uab_pkg;
  // register port widths
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // register offsets (word index on the register port)
  localparam logic [2:0] ADDR_RATE_CTRL = 3'h0; // rate_control_reg
  localparam logic [2:0] ADDR_DIV_LOW = 3'h1; // rate_divisor_low
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h2; // rate_divisor_high
  localparam logic [2:0] ADDR_RX_BUF = 3'h3; // receive_buffer
  localparam logic [2:0] ADDR_STATUS = 3'h4; // receive flag and busy state
  localparam logic [2:0] ADDR_TX_CTRL = 3'h5; // high speed and sync selects

  // rate_control_reg bit positions
  localparam int unsigned BIT_AB_EN = 0; // autobaud_enable
  localparam int unsigned BIT_WAKE_EN = 1; // wake_up_enable
  localparam int unsigned BIT_WIDE = 3; // wide_divisor_select
  localparam int unsigned BIT_AB_OVF = 7; // autobaud_overflow_flag

  // tx control bit positions
  localparam int unsigned BIT_HIGH_SPEED = 2; // high_speed_select
  localparam int unsigned BIT_SYNC = 4; // synchronous mode select

  // status bit positions
  localparam int unsigned BIT_RX_FLAG = 0; // receive_flag
  localparam int unsigned BIT_AB_MODE = 1; // autobaud_mode busy

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0000;

  // counter clock prescale counts during measurement
  localparam int unsigned PRE_W = 9;
  localparam logic [8:0] PRE_TERM_512 = 9'h1ff; // 512 clocks, no select bit set
  localparam logic [8:0] PRE_TERM_128 = 9'h07f; // 128 clocks, one select bit set
  localparam logic [8:0] PRE_TERM_32 = 9'h01f; // 32 clocks, both select bits set

  // high speed bit rate: fosc / (4 * (divisor + 1))
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  // rising edges of the sync character that close the measurement
  localparam logic [2:0] EDGE_LAST = 3'h5;

  // measurement sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CLEAR = 3'b001,
    ST_BREAK_LOW = 3'b010,
    ST_BREAK_END = 3'b011,
    ST_WAIT_START = 3'b100,
    ST_WAIT_RISE = 3'b101,
    ST_COUNT = 3'b110
  } uab_state_type;
endpackage

/* File: hdl/uab_prescaler.sv */
/*
  prescaler for the measurement counter: one-cycle tick every 512, 128
  or 32 clocks as picked by the number of speed select bits set.
  assumes clear restarts the phase so the first tick is a full period late.
*/
`timescale 1ns/1ps
`default_nettype none
module uab_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic run,
  input wire logic [1:0] sel_count,
  // tick out
  output logic tick
);
  logic [8:0] cnt_r; // phase counter, held at zero while not running
  logic [8:0] cnt_nxt;
  logic tick_r; // registered tick
  logic [8:0] term; // last count of the period
  logic at_term;

  // divide choice: none set 512, one set 128, both set 32
  assign term = (sel_count == 2'h0) ? uab_pkg::PRE_TERM_512 :
                (sel_count == 2'h1) ? uab_pkg::PRE_TERM_128 : uab_pkg::PRE_TERM_32;
  assign at_term = (cnt_r == term);
  assign cnt_nxt = (clear || !run || at_term) ? 9'h000 : cnt_r + 9'h001;
  assign tick = tick_r;

  // phase counter, held at zero while not running
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 9'h000;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= run && !clear && at_term;
    end
  end
endmodule
`default_nettype wire
